/* File: rtl/blc_bank.sv */
// brownout guard upper-tier register bank with tier-3 gain engine
// assumes supply codes and the tier-2 compare come from same-clock logic
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps

// What this block does
// - tier3 attack rate, bits 7-5, 2.5-500 us
// - tier3 release step, bits 4-1, reset 3
// - tier3 release rate 5-1000 ms, reset 1
// - tier3 max attenuation 0 to -31 dB
// - tier3 threshold code, meaning follows source select
// - tier3 hold time; code 7 holds until clear
// - tier3 disable bit stops threshold triggering
// - read-only state code of engine
// - tier2 dwell time 0-8000 us, reset 0
// - tier2 attack step size, reset 1
// - hold clear bit clears itself
// - combined attenuation cap, 2f-7f disables
module blc_bank import blc_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] battery_supply_code,
	input wire logic [7:0] output_stage_supply_code,
	input wire logic tier2_supply_below,
	output logic [9:0] attenuation_q4,
	output logic supply_source_select,
	output logic tier2_attack_enable,
	output logic [3:0] tier2_attack_step,
	output logic irq
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0] t3_atk_rls, t3_rate_attn, t3_threshold, t2_dwell_step;
	logic [2:0] tier3_hold_time;
	logic tier3_disable, state_readback_freeze, hold_clear;
	logic [6:0] combined_attenuation_cap;
	logic [3:0] guard_state_code;
	logic [IRQ_W-1:0] irq_status, irq_mask, irq_events;
	logic aw_held, w_held;
	logic [5:0] aw_idx;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire, wr_hit, rd_hit;
	logic [31:0] rd_word;
	logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;
	logic tick;
	blc_state_t state, next_state;
	logic [9:0] next_att, att_limit, step_attack, step_release;
	logic [10:0] att_sum;
	logic rate_start, hold_start, hold_stop, rate_exp, hold_exp;
	logic [TW-1:0] rate_load, hold_load, dwell_load;
	logic below, dwell_start, dwell_exp, t2_below_q;

	// ------------------------------------------------------------
	// table lookups, converted to 0.5 us ticks
	// ------------------------------------------------------------
	function automatic logic [TW-1:0] atk_ticks(input logic [2:0] c);
		return TW'(ATK_RATE_US_X10[c] / 5);
	endfunction
	function automatic logic [TW-1:0] ms_ticks(input int ms);
		return TW'(ms * 2000);
	endfunction

	// ------------------------------------------------------------
	// AXI4-Lite write channel; address and data taken in any order
	// ------------------------------------------------------------
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_idx <= s_axi_awaddr[ADDR_W-1:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// decode of mapped words; unmapped answers with a slave error
	always_comb begin
		unique case (aw_idx)
			IDX_T3_ATK_RLS, IDX_T3_RATE_ATTN, IDX_T3_THRESHOLD,
			IDX_T3_HOLD_STATE, IDX_T2_DWELL_STEP, IDX_CONTROL,
			IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_ATTEN: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// configuration registers; byte lane 0 carries the fields, byte lane 1 the cap
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t3_atk_rls <= RST_T3_ATK_RLS;
			t3_rate_attn <= RST_T3_RATE_ATTN;
			t3_threshold <= RST_T3_THRESHOLD;
			tier3_hold_time <= RST_T3_HOLD_DIS[7:5];
			tier3_disable <= RST_T3_HOLD_DIS[F_DIS3];
			t2_dwell_step <= RST_T2_DWELL_STEP;
			supply_source_select <= 1'b0;
			state_readback_freeze <= 1'b0;
			irq_mask <= '0;
		end else if (wr_fire && w_strb[0]) begin
			unique case (aw_idx)
				IDX_T3_ATK_RLS: t3_atk_rls <= {w_data[7:1], 1'b0};
				IDX_T3_RATE_ATTN: t3_rate_attn <= w_data[7:0];
				IDX_T3_THRESHOLD: t3_threshold <= w_data[7:0];
				IDX_T3_HOLD_STATE: begin
					tier3_hold_time <= w_data[7:5];
					tier3_disable <= w_data[F_DIS3];
				end
				IDX_T2_DWELL_STEP: t2_dwell_step <= {w_data[7:1], 1'b0};
				IDX_CONTROL: begin
					supply_source_select <= w_data[F_CTL_SRC];
					state_readback_freeze <= w_data[F_CTL_FREEZE];
				end
				IDX_IRQ_MASK: irq_mask <= w_data[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// cap sits in byte lane 1 of the control word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			combined_attenuation_cap <= RST_CAP;
		end else if (wr_fire && w_strb[1] && aw_idx == IDX_CONTROL) begin
			combined_attenuation_cap <= w_data[F_CTL_CAP_LSB +: 7];
		end
	end

	// one-cycle pulse; reads back as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_clear <= 1'b0;
		end else begin
			hold_clear <= wr_fire && w_strb[0] && aw_idx == IDX_CONTROL
				&& w_data[F_CTL_HCLR];
		end
	end
	assign tier2_attack_step = t2_dwell_step[F_STEP_LSB +: 4];

	// ------------------------------------------------------------
	// interrupt status, write one to clear, new events win
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_fire && w_strb[0] && aw_idx == IDX_IRQ_STATUS) begin
				irq_status <= (irq_status & ~w_data[IRQ_W-1:0]) | irq_events;
			end else begin
				irq_status <= irq_status | irq_events;
			end
			irq <= |(irq_status & irq_mask);
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case (s_axi_araddr[ADDR_W-1:2])
			IDX_T3_ATK_RLS: rd_word[7:0] = t3_atk_rls;
			IDX_T3_RATE_ATTN: rd_word[7:0] = t3_rate_attn;
			IDX_T3_THRESHOLD: rd_word[7:0] = t3_threshold;
			IDX_T3_HOLD_STATE: rd_word[7:0] = {tier3_hold_time,
				tier3_disable, guard_state_code};
			IDX_T2_DWELL_STEP: rd_word[7:0] = t2_dwell_step;
			IDX_CONTROL: rd_word[14:0] = {combined_attenuation_cap, 6'h00,
				state_readback_freeze, supply_source_select};
			IDX_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status;
			IDX_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
			IDX_ATTEN: rd_word[9:0] = attenuation_q4;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// 0.5 us timebase; shortening TICK_CYCLES speeds all timers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else if (tick_cnt == '0) begin
			tick_cnt <= ($bits(tick_cnt))'(TICK_CYCLES - 1);
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt - 1'b1;
			tick <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// tier-3 engine
	// ------------------------------------------------------------
	// threshold compares in the scale of the selected supply
	assign below = !tier3_disable && ((supply_source_select ?
		output_stage_supply_code : battery_supply_code) < t3_threshold);
	assign step_attack = 10'(STEP_Q4[tier2_attack_step]);
	assign step_release = 10'(STEP_Q4[t3_atk_rls[F_STEP_LSB +: 4]]);
	assign hold_load = ms_ticks(HOLD_MS[tier3_hold_time]);

	// the smaller of tier maximum and the device-wide cap
	always_comb begin
		att_limit = {1'b0, t3_rate_attn[4:0], 4'h0};
		if (combined_attenuation_cap < CAP_OFF_MIN
				&& {combined_attenuation_cap, 4'h0} < {1'b0, att_limit}) begin
			att_limit = {combined_attenuation_cap[5:0], 4'h0};
		end
	end

	always_comb begin
		next_state = state;
		next_att = attenuation_q4;
		rate_start = 1'b0;
		rate_load = atk_ticks(t3_atk_rls[7:5]);
		hold_start = 1'b0;
		hold_stop = 1'b0;
		att_sum = 11'({1'b0, attenuation_q4} + {1'b0, step_attack});
		unique case (state)
			ST_IDLE: if (below) begin
				next_state = ST_ATTACK;
				rate_start = 1'b1;
			end
			ST_ATTACK: if (!below || attenuation_q4 >= att_limit) begin
				next_state = ST_HOLD;
				hold_start = 1'b1;
			end else if (rate_exp) begin
				rate_start = 1'b1;
				next_att = (att_sum >= {1'b0, att_limit}) ? att_limit :
					att_sum[9:0];
			end
			ST_HOLD: if (below && attenuation_q4 < att_limit) begin
				next_state = ST_ATTACK;
				rate_start = 1'b1;
				hold_stop = 1'b1;
			end else if (below) begin
				hold_start = 1'b1; // hold counts from recovery
			end else if (tier3_hold_time == HOLD_INFINITE ? hold_clear
					: hold_exp) begin
				next_state = ST_RELEASE;
				hold_stop = 1'b1;
				rate_start = 1'b1;
				rate_load = ms_ticks(RLS_RATE_MS[t3_rate_attn[7:5]]);
			end
			ST_RELEASE: if (below) begin
				next_state = ST_ATTACK;
				rate_start = 1'b1;
			end else if (attenuation_q4 == '0) begin
				next_state = ST_IDLE;
			end else if (rate_exp) begin
				rate_start = 1'b1;
				rate_load = ms_ticks(RLS_RATE_MS[t3_rate_attn[7:5]]);
				next_att = (attenuation_q4 > step_release) ?
					attenuation_q4 - step_release : '0;
			end
		endcase
		// a lowered limit takes effect at once
		if (next_att > att_limit) begin
			next_att = att_limit;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			attenuation_q4 <= '0;
		end else begin
			state <= next_state;
			attenuation_q4 <= next_att;
		end
	end

	assign irq_events[IRQ_ATTACK] = next_state == ST_ATTACK
		&& state != ST_ATTACK;
	assign irq_events[IRQ_HOLD] = next_state == ST_HOLD && state != ST_HOLD;
	assign irq_events[IRQ_IDLE] = next_state == ST_IDLE
		&& state == ST_RELEASE;

	// readback code stands still while software has it frozen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			guard_state_code <= CODE_IDLE;
		end else if (!state_readback_freeze) begin
			unique case (state)
				ST_IDLE: guard_state_code <= CODE_IDLE;
				ST_ATTACK: guard_state_code <= CODE_ATTACK3;
				ST_HOLD: guard_state_code <= CODE_HOLD3;
				ST_RELEASE: guard_state_code <= CODE_RELEASE3;
			endcase
		end
	end

	blc_interval_timer #(.W(TW)) u_rate_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(rate_start),
		.stop(1'b0),
		.load(rate_load),
		.tick(tick),
		.expired(rate_exp)
	);

	blc_interval_timer #(.W(TW)) u_hold_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(hold_start),
		.stop(hold_stop),
		.load(hold_load),
		.tick(tick),
		.expired(hold_exp)
	);

	// ------------------------------------------------------------
	// tier-2 dwell qualifier
	// ------------------------------------------------------------
	assign dwell_load = TW'(DWELL_US[t2_dwell_step[7:5]] * 2);
	assign dwell_start = tier2_supply_below && !t2_below_q;

	blc_interval_timer #(.W(TW)) u_dwell_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(dwell_start),
		.stop(!tier2_supply_below),
		.load(dwell_load),
		.tick(tick),
		.expired(dwell_exp)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t2_below_q <= 1'b0;
			tier2_attack_enable <= 1'b0;
		end else begin
			t2_below_q <= tier2_supply_below;
			tier2_attack_enable <= tier2_supply_below && dwell_exp;
		end
	end
endmodule // blc_bank

/* File: shared/blc_pkg.sv */
// brownout level configuration bank: offsets, fields, resets, time tables
// assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus
package blc_pkg;

	// ------------------------------------------------------------
	// clock and timebase
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int TICK_NS = 500;
	localparam int TICK_CYCLES_DEF = (TICK_NS * CLK_MHZ + 999) / 1000;
	localparam int TW = 23;

	// ------------------------------------------------------------
	// register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_T3_ATK_RLS = 6'h20;
	localparam logic [5:0] IDX_T3_RATE_ATTN = 6'h21;
	localparam logic [5:0] IDX_T3_THRESHOLD = 6'h22;
	localparam logic [5:0] IDX_T3_HOLD_STATE = 6'h23;
	localparam logic [5:0] IDX_T2_DWELL_STEP = 6'h24;
	localparam logic [5:0] IDX_CONTROL = 6'h30;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h31;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h32;
	localparam logic [5:0] IDX_ATTEN = 6'h33;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_T3_ATK_RLS = 8'h06;
	localparam logic [7:0] RST_T3_RATE_ATTN = 8'h2c;
	localparam logic [7:0] RST_T3_THRESHOLD = 8'h4c;
	localparam logic [7:0] RST_T3_HOLD_DIS = 8'h20;
	localparam logic [7:0] RST_T2_DWELL_STEP = 8'h02;
	localparam logic [6:0] RST_CAP = 7'h32;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int F_HI3_LSB = 5;
	localparam int F_STEP_LSB = 1;
	localparam int F_DIS3 = 4;
	localparam int F_CTL_SRC = 0;
	localparam int F_CTL_FREEZE = 1;
	localparam int F_CTL_HCLR = 2;
	localparam int F_CTL_CAP_LSB = 8;
	localparam logic [6:0] CAP_OFF_MIN = 7'h2f;
	localparam logic [2:0] HOLD_INFINITE = 3'h7;
	localparam int IRQ_W = 3;
	localparam int IRQ_ATTACK = 0;
	localparam int IRQ_HOLD = 1;
	localparam int IRQ_IDLE = 2;

	// ------------------------------------------------------------
	// time tables in their printed units
	// ------------------------------------------------------------
	localparam int ATK_RATE_US_X10 [8] = '{25, 50, 100, 250, 500, 1000,
		2500, 5000};
	localparam int RLS_RATE_MS [8] = '{5, 10, 25, 50, 100, 250, 500, 1000};
	localparam int HOLD_MS [8] = '{0, 10, 100, 250, 500, 1000, 2000, 0};
	localparam int DWELL_US [8] = '{0, 100, 250, 500, 1000, 2000, 4000,
		8000};
	// gain step sizes in 1/16 dB units, nearest value
	localparam int STEP_Q4 [16] = '{1, 8, 14, 21, 27, 33, 40, 46, 52, 59,
		65, 71, 78, 84, 90, 96};

	// ------------------------------------------------------------
	// engine state and readback codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ATTACK = 2'b01,
		ST_HOLD = 2'b10,
		ST_RELEASE = 2'b11
	} blc_state_t;
	localparam logic [3:0] CODE_IDLE = 4'h0;
	localparam logic [3:0] CODE_ATTACK3 = 4'h1;
	localparam logic [3:0] CODE_HOLD3 = 4'h5;
	localparam logic [3:0] CODE_RELEASE3 = 4'h9;

endpackage

/* File: rtl/blc_interval_timer.sv */
// countdown timer stepped by a shared timebase tick
// assumes start and tick come from logic on the same clock
`timescale 1ns/100ps
module blc_interval_timer #(
	parameter int W = 23
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic stop,
	input wire logic [W-1:0] load,
	input wire logic tick,
	output logic expired
);
	logic [W-1:0] count;
	logic running;

	// load wins over tick so a restart always begins a full interval
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
			running <= 1'b0;
		end else if (start) begin
			count <= load;
			running <= 1'b1;
		end else if (stop) begin
			running <= 1'b0;
		end else if (running && tick && count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign expired = running && (count == '0);
endmodule // blc_interval_timer

/* File: sim/blc_bank_chk.sv */
// port checker for the brownout guard upper-tier bank
// assumes it is bound onto every blc_bank, one clock domain
`timescale 1ns/100ps
module blc_bank_chk import blc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic tier2_supply_below,
	input wire logic [9:0] attenuation_q4,
	input wire logic supply_source_select,
	input wire logic tier2_attack_enable,
	input wire logic [3:0] tier2_attack_step,
	input wire logic irq
);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking dcb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// no attenuation beyond the widest tier-3 limit of 31 dB
	attn_ceiling_a: assert property (attenuation_q4 <= 10'h1f0)
		else $error("attenuation above 31 dB");
	attack_step_a: assert property (attenuation_q4 > $past(attenuation_q4)
		|-> attenuation_q4 - $past(attenuation_q4) <= 10'd96)
		else $error("attack step above 6 dB");
	release_step_a: assert property (attenuation_q4 < $past(attenuation_q4)
		|-> $past(attenuation_q4) - attenuation_q4 <= 10'd96)
		else $error("release step above 6 dB");
	dwell_rise_a: assert property ($rose(tier2_attack_enable)
		|-> $past(tier2_supply_below))
		else $error("tier2 enable without supply below");
	dwell_drop_a: assert property (!tier2_supply_below
		|=> !tier2_attack_enable)
		else $error("tier2 enable kept after recovery");
	step_reset_a: assert property ($rose(aresetn)
		|-> tier2_attack_step == 4'h1)
		else $error("tier2 step reset value wrong");
	out_reset_a: assert property ($rose(aresetn)
		|-> !supply_source_select && attenuation_q4 == 10'h000 && !irq)
		else $error("outputs not at reset value");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken during read answer");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	write_busy_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during write answer");

	// main scenarios reached
	cover property ($rose(irq));
	cover property ($rose(tier2_attack_enable));
	cover property ($fell(attenuation_q4 != 10'h000));
endmodule // blc_bank_chk

bind blc_bank blc_bank_chk blc_bank_chk_i (.*);

/* File: sim/tb_blc_bank.sv */
// self-checking bench for the brownout guard upper-tier bank
// assumes a one-cycle timebase tick so long times stay short
`timescale 1ns/100ps
module tb_blc_bank import blc_pkg::*;;
	// ------------------------------------------------------------
	// signals, clock and bus tasks
	// ------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0;
	logic [ADDR_W-1:0] s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq, supply_source_select, tier2_attack_enable;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] battery_supply_code = 8'h50;
	logic [7:0] output_stage_supply_code = 8'h50;
	logic tier2_supply_below = 1'b0;
	logic [9:0] attenuation_q4;
	logic [3:0] tier2_attack_step;
	int failures = 0, checks_done = 0, cyc = 0;

	blc_bank #(.TICK_CYCLES(1)) blc_bank_i (.*);

	// clock, and a ceiling on the whole run
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// payload held until each channel's own ready
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50) failures++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50) failures++;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("reg %h", a), d, e);
		chk("rresp", 32'(r), 32'h0);
	endtask

	// bounded wait, no fixed latency assumed
	task automatic wait_attn(input logic [9:0] e, input int lim);
		int n;
		n = 0;
		while (attenuation_q4 !== e && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk("attenuation", 32'(attenuation_q4), 32'(e));
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] a [8] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'hc0,
			8'hc4, 8'hc8};
		logic [31:0] e [8] = '{32'h06, 32'h2c, 32'h4c, 32'h20, 32'h02,
			32'h3200, 32'h0, 32'h0};
		for (int i = 0; i < 8; i++) rc(a[i], e[i]);
		chk("t2 step", 32'(tier2_attack_step), 32'h1);
		$display("test reset done");
	endtask

	task automatic t_rw();
		logic [1:0] r;
		logic [31:0] d;
		wr(8'h80, 32'hff, r);
		rc(8'h80, 32'hfe);
		wr(8'h84, 32'hff, r);
		rc(8'h84, 32'hff);
		// threshold stays under the idle supply code so the engine rests
		wr(8'h88, 32'h3a, r);
		rc(8'h88, 32'h3a);
		wr(8'h8c, 32'hff, r);
		rc(8'h8c, 32'hf0);
		wr(8'h90, 32'hff, r);
		rc(8'h90, 32'hfe);
		chk("t2 step", 32'(tier2_attack_step), 32'hf);
		wr(8'hc0, 32'h2f00, r);
		rc(8'hc0, 32'h2f00);
		wr(8'h00, 32'hff, r);
		chk("bresp", 32'(r), 32'h2);
		rd(8'h00, d, r);
		chk("rresp", 32'(r), 32'h2);
		chk("rdata", d, 32'h0);
		rc(8'hcc, 32'h0);
		$display("test rw done");
	endtask

	// dwell 100 us is 200 ticks
	task automatic t_dwell();
		logic [1:0] r;
		int n;
		wr(8'h90, 32'h22, r);
		tier2_supply_below <= 1'b1;
		repeat (150) @(posedge aclk);
		chk("t2 enable", 32'(tier2_attack_enable), 32'h0);
		n = 0;
		while (tier2_attack_enable !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		chk("t2 enable", 32'(tier2_attack_enable), 32'h1);
		tier2_supply_below <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("t2 enable", 32'(tier2_attack_enable), 32'h0);
		$display("test dwell done");
	endtask

	// attack 2.5 us steps of 0.5 dB to 1 dB, infinite hold, 5 ms release
	task automatic t_engine();
		logic [1:0] r;
		wr(8'h88, 32'h40, r);
		wr(8'h84, 32'h01, r);
		wr(8'h80, 32'h1e, r);
		wr(8'h8c, 32'he0, r);
		wr(8'hc8, 32'h1, r);
		battery_supply_code <= 8'h30;
		wait_attn(10'd8, 12);
		wait_attn(10'd16, 12);
		chk("irq", 32'(irq), 32'h1);
		rc(8'h8c, 32'he5);
		battery_supply_code <= 8'h50;
		repeat (100) @(posedge aclk);
		rc(8'h8c, 32'he5);
		wr(8'hc0, 32'h3202, r);
		wr(8'hc0, 32'h3206, r);
		rc(8'hc0, 32'h3202);
		repeat (9000) @(posedge aclk);
		chk("attenuation", 32'(attenuation_q4), 32'd16);
		wait_attn(10'd0, 2000);
		rc(8'h8c, 32'he5);
		wr(8'hc0, 32'h3200, r);
		rc(8'h8c, 32'he0);
		rc(8'hc4, 32'h7);
		wr(8'hc4, 32'h1, r);
		repeat (2) @(posedge aclk);
		chk("irq", 32'(irq), 32'h0);
		rc(8'hc4, 32'h6);
		wr(8'hc4, 32'h6, r);
		rc(8'hc4, 32'h0);
		$display("test engine done");
	endtask

	// disabled tier and unselected supply must not trigger
	task automatic t_gate();
		logic [1:0] r;
		wr(8'h8c, 32'h10, r);
		battery_supply_code <= 8'h30;
		repeat (60) @(posedge aclk);
		chk("attenuation", 32'(attenuation_q4), 32'h0);
		rc(8'hc4, 32'h0);
		wr(8'hc0, 32'h3201, r);
		chk("source", 32'(supply_source_select), 32'h1);
		wr(8'h8c, 32'h00, r);
		repeat (60) @(posedge aclk);
		chk("attenuation", 32'(attenuation_q4), 32'h0);
		output_stage_supply_code <= 8'h30;
		wait_attn(10'd8, 20);
		// a zero device cap pulls the attenuation down at once
		wr(8'hc0, 32'h0001, r);
		wait_attn(10'd0, 4);
		$display("test gate done");
	endtask

	// reset for four cycles, then the scenarios in turn
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_rw();
		t_dwell();
		t_engine();
		t_gate();
		stop_test();
	end
endmodule // tb_blc_bank
